// >>> rtl/brac_pkg.sv
package brac_pkg;

    localparam int XTAL_FAST_HZ = 32768;
    localparam int XTAL_SLOW_HZ = 32000;
    localparam int TRIM_SPAN_S = 20;

    localparam logic [3:0] REG_SECONDS = 4'h0;
    localparam logic [3:0] REG_MINUTES = 4'h1;
    localparam logic [3:0] REG_HOURS = 4'h2;
    localparam logic [3:0] REG_WEEKDAY = 4'h3;
    localparam logic [3:0] REG_DATE = 4'h4;
    localparam logic [3:0] REG_MONTH = 4'h5;
    localparam logic [3:0] REG_YEAR = 4'h6;
    localparam logic [3:0] REG_TRIM = 4'h7;
    localparam logic [3:0] REG_AL1_MIN = 4'h8;
    localparam logic [3:0] REG_AL1_HOUR = 4'h9;
    localparam logic [3:0] REG_AL1_DAYS = 4'hA;
    localparam logic [3:0] REG_AL2_MIN = 4'hB;
    localparam logic [3:0] REG_AL2_HOUR = 4'hC;
    localparam logic [3:0] REG_AL2_DAYS = 4'hD;
    localparam logic [3:0] REG_CTRL1 = 4'hE;
    localparam logic [3:0] REG_CTRL2 = 4'hF;

    localparam logic [7:0] MASK_SEC = 8'h7F;
    localparam logic [7:0] MASK_HOUR = 8'h3F;
    localparam logic [7:0] MASK_WDAY = 8'h07;
    localparam logic [7:0] MASK_DATE = 8'h3F;
    localparam logic [7:0] MASK_MONTH = 8'h1F;

    localparam int CTRL2_FMT_BIT = 5;
    localparam int CTRL2_ADJ_BIT = 4;
    localparam int CTRL2_CLOCK_OUT_CONTROL_BIT = 3;
    localparam int CTRL2_PERIODIC_FLAG_BIT = 2;
    localparam int CTRL2_AFG1_BIT = 1;
    localparam int CTRL2_AFG2_BIT = 0;

    localparam logic [7:0] RST_HOURS = 8'h00;
    localparam logic [7:0] RST_DATE = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic RST_FMT24 = 1'b1;

    typedef enum logic [2:0] {
        CYC_OFF, CYC_LOW, CYC_2HZ, CYC_1HZ, CYC_SEC, CYC_MIN, CYC_HOUR, CYC_MONTH
    } brac_cycle_e;

    typedef enum {HS_IDLE, HS_WAIT} brac_hs_e;

    typedef struct packed {
        logic we;
        logic [3:0] addr;
        logic [7:0] wdata;
    } brac_req_s;

    typedef struct packed {
        logic alarm_one_enable;
        logic alarm_two_enable;
        logic route_select_high;
        logic route_select_low;
        logic test;
        brac_cycle_e cycle;
    } brac_ctrl1_s;

endpackage : brac_pkg

// >>> rtl/brac_core.sv
// Behaviour
// - Two independent alarms compare weekday, hour and minute with current time.
// - Each alarm has per-weekday enables; fires only on enabled days.
// - Each alarm match is pollable through its own flag bit.
// - Trim register corrects rate about +-189ppm (+-194ppm slow crystal), 3ppm steps.
// - Crystal select picks 32.768 or 32.000 kHz divider.
// - Oscillator halt is recorded in a readable status bit.
// - Periodic interrupt at 2Hz, 1Hz, second, minute, hour or monthly.
// - 2Hz and 1Hz are free pulses; second to month are held levels.
// - Periodic interrupt is routed to either interrupt pin by register.
// - Periodic output state is mirrored in a readable flag.
// - Crystal clock drives second pin by default; control bit gates it.
// - Year keeps two BCD digits only; century left to software.
// - Four-bit address decodes sixteen byte registers at fixed offsets.
// - All listed bits read and write, except adjust/halt position.
// - Empty bit positions are read-only and read as zero.
// - Control two D4 is seconds adjust on write, halt status on read.
// - Any control two write with running oscillator clears halt status.
// - Halt status forces crystal, trim, cycle, enables, routing, clock, test to zero.
// - Two-digit years divisible by four are leap years.
// - Cycle field: off, low, 2Hz, 1Hz, then second/minute/hour/month levels.
// - Route bits distribute alarms and periodic; alarm one first pin, clock second.
// - Hour format bit selects 12-hour with PM bit or 24-hour coding.
`timescale 1ns/100ps
`default_nettype none

module brac_core #(
    parameter int DIV_FAST = brac_pkg::XTAL_FAST_HZ,
    parameter int DIV_SLOW = brac_pkg::XTAL_SLOW_HZ,
    parameter int TRIM_SPAN = brac_pkg::TRIM_SPAN_S
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic osc_clk_i,
    input wire logic req_valid_i,
    input wire brac_pkg::brac_req_s req_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    output logic irq_out_first_o,
    output logic irq_out_first_oe_n_o,
    output logic irq_out_second_o,
    output logic irq_out_second_oe_n_o
);

    generate
        if (DIV_FAST < 512 || DIV_FAST > 65000 || DIV_SLOW < 512 || DIV_SLOW > 65000 || TRIM_SPAN < 1
            || TRIM_SPAN > 255) begin : g_bad_param
            $error("brac_core: divider or trim span out of range");
        end
    endgenerate

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            8'h02: month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction : month_len

    // Host side, clk_i domain. The request is held stable while its toggle crosses.
    brac_pkg::brac_hs_e hs_state;
    brac_pkg::brac_req_s req_q;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic [7:0] rd_q;

    assign req_ready_o = (hs_state == brac_pkg::HS_IDLE);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hs_state <= brac_pkg::HS_IDLE;
            req_q <= '0;
            req_tgl <= 1'b0;
            ack_seen <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 8'h00;
        end else begin
            rsp_valid_o <= 1'b0;
            case (hs_state)
                brac_pkg::HS_IDLE: begin
                    if (req_valid_i) begin
                        req_q <= req_i;
                        req_tgl <= ~req_tgl;
                        hs_state <= brac_pkg::HS_WAIT;
                    end
                end
                brac_pkg::HS_WAIT: begin
                    if (ack_s2 != ack_seen) begin
                        ack_seen <= ack_s2;
                        rsp_data_o <= rd_q;
                        rsp_valid_o <= 1'b1;
                        hs_state <= brac_pkg::HS_IDLE;
                    end
                end
                default: hs_state <= brac_pkg::HS_IDLE;
            endcase
        end
    end

    // Oscillator domain. Its reset stands for the halt condition.
    logic rst_s1;
    logic osc_rst;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    logic op_go;
    logic wr_go;

    always_ff @(posedge osc_clk_i) begin
        rst_s1 <= srst_i;
        osc_rst <= rst_s1;
    end

    always_ff @(posedge osc_clk_i) begin
        if (osc_rst) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_seen <= 1'b0;
            ack_tgl <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_seen <= req_s2;
            if (op_go) begin
                ack_tgl <= ~ack_tgl;
            end
        end
    end

    assign op_go = (req_s2 != req_seen);
    assign wr_go = op_go && req_q.we;

    logic [7:0] sec, min, hr, wday, date, mon, yr;
    logic [7:0] trim;
    logic [7:0] al_min [2];
    logic [7:0] al_hour [2];
    logic [6:0] al_days [2];
    brac_pkg::brac_ctrl1_s ctrl1;
    logic fmt24;
    logic clock_out_control;
    logic osc_halt_status;
    logic periodic_flag;
    logic [1:0] afg;

    logic adj_go;
    assign adj_go = wr_go && req_q.addr == brac_pkg::REG_CTRL2 && req_q.wdata[brac_pkg::CTRL2_ADJ_BIT];

    // Divider with trim applied to one second out of every TRIM_SPAN seconds.
    logic [16:0] sub;
    logic [7:0] span_cnt;
    logic signed [17:0] period;
    logic signed [17:0] trim_adj;
    logic [5:0] trim_mag;
    logic sec_tick;

    always_comb begin
        trim_mag = ~trim[5:0];
        trim_adj = '0;
        if (!trim[6]) begin
            if (trim[5:0] > 6'h01) begin
                trim_adj = 18'(({12'h000, trim[5:0]} - 18'h1) << 1);
            end
        end else begin
            trim_adj = -18'(({12'h000, trim_mag} + 18'h1) << 1);
        end
        period = trim[7] ? 18'(DIV_SLOW) : 18'(DIV_FAST);
        if (span_cnt == 8'h00) begin
            period = period + trim_adj;
        end
    end

    // A trim or crystal write can shorten the period below the running count; the compare
    // is not exact so that the count cannot run on to its wrap and stall the time.
    assign sec_tick = (sub >= 17'(period - 18'sd1));

    always_ff @(posedge osc_clk_i) begin
        if (osc_rst || adj_go) begin
            sub <= '0;
            span_cnt <= 8'h00;
        end else if (sec_tick) begin
            sub <= '0;
            span_cnt <= (span_cnt == 8'(TRIM_SPAN - 1)) ? 8'h00 : span_cnt + 8'h01;
        end else begin
            sub <= sub + 17'h1;
        end
    end

    // Time and calendar carry chain.
    logic [7:0] next_sec, next_min, next_hr, next_wday, next_date, next_mon, next_yr;
    logic min_step, hour_step, day_step, month_step;

    always_comb begin
        next_sec = sec;
        next_min = min;
        next_hr = hr;
        next_wday = wday;
        next_date = date;
        next_mon = mon;
        next_yr = yr;
        min_step = 1'b0;
        hour_step = 1'b0;
        day_step = 1'b0;
        month_step = 1'b0;
        if (adj_go) begin
            next_sec = 8'h00;
            min_step = (sec >= 8'h30);
        end else if (sec_tick) begin
            next_sec = (sec == 8'h59) ? 8'h00 : bcd_inc(sec);
            min_step = (sec == 8'h59);
        end
        if (min_step) begin
            next_min = (min == 8'h59) ? 8'h00 : bcd_inc(min);
            hour_step = (min == 8'h59);
        end
        if (hour_step) begin
            if (fmt24) begin
                day_step = (hr == 8'h23);
                next_hr = day_step ? 8'h00 : bcd_inc(hr);
            end else if (hr[4:0] == 5'h12) begin
                next_hr = {hr[7:6], hr[5], 5'h01};
            end else if (hr[4:0] == 5'h11) begin
                next_hr = {hr[7:6], ~hr[5], 5'h12};
                day_step = hr[5];
            end else begin
                next_hr = {hr[7:5], 5'(bcd_inc({3'b000, hr[4:0]}))};
            end
        end
        if (day_step) begin
            next_wday = (wday == 8'h06) ? 8'h00 : wday + 8'h01;
            month_step = (date == month_len(mon, yr));
            next_date = month_step ? 8'h01 : bcd_inc(date);
        end
        if (month_step) begin
            next_mon = (mon == 8'h12) ? 8'h01 : bcd_inc(mon);
            if (mon == 8'h12) begin
                next_yr = (yr == 8'h99) ? 8'h00 : bcd_inc(yr);
            end
        end
    end

    // A host write to a time register in the same cycle as a tick wins, dropping that tick.
    always_ff @(posedge osc_clk_i) begin
        if (osc_rst) begin
            sec <= 8'h00;
            min <= 8'h00;
            hr <= brac_pkg::RST_HOURS;
            wday <= 8'h00;
            date <= brac_pkg::RST_DATE;
            mon <= brac_pkg::RST_MONTH;
            yr <= 8'h00;
        end else if (wr_go && req_q.addr <= brac_pkg::REG_YEAR) begin
            case (req_q.addr)
                brac_pkg::REG_SECONDS: sec <= req_q.wdata & brac_pkg::MASK_SEC;
                brac_pkg::REG_MINUTES: min <= req_q.wdata & brac_pkg::MASK_SEC;
                brac_pkg::REG_HOURS: hr <= req_q.wdata & brac_pkg::MASK_HOUR;
                brac_pkg::REG_WEEKDAY: wday <= req_q.wdata & brac_pkg::MASK_WDAY;
                brac_pkg::REG_DATE: date <= req_q.wdata & brac_pkg::MASK_DATE;
                brac_pkg::REG_MONTH: mon <= req_q.wdata & brac_pkg::MASK_MONTH;
                default: yr <= req_q.wdata;
            endcase
        end else begin
            sec <= next_sec;
            min <= next_min;
            hr <= next_hr;
            wday <= next_wday;
            date <= next_date;
            mon <= next_mon;
            yr <= next_yr;
        end
    end

    always_ff @(posedge osc_clk_i) begin
        if (osc_rst) begin
            al_min[0] <= 8'h00;
            al_min[1] <= 8'h00;
            al_hour[0] <= 8'h00;
            al_hour[1] <= 8'h00;
            al_days[0] <= 7'h00;
            al_days[1] <= 7'h00;
            fmt24 <= brac_pkg::RST_FMT24;
        end else if (wr_go) begin
            case (req_q.addr)
                brac_pkg::REG_AL1_MIN: al_min[0] <= req_q.wdata & brac_pkg::MASK_SEC;
                brac_pkg::REG_AL1_HOUR: al_hour[0] <= req_q.wdata & brac_pkg::MASK_HOUR;
                brac_pkg::REG_AL1_DAYS: al_days[0] <= req_q.wdata[6:0];
                brac_pkg::REG_AL2_MIN: al_min[1] <= req_q.wdata & brac_pkg::MASK_SEC;
                brac_pkg::REG_AL2_HOUR: al_hour[1] <= req_q.wdata & brac_pkg::MASK_HOUR;
                brac_pkg::REG_AL2_DAYS: al_days[1] <= req_q.wdata[6:0];
                brac_pkg::REG_CTRL2: fmt24 <= req_q.wdata[brac_pkg::CTRL2_FMT_BIT];
                default: ;
            endcase
        end
    end

    // Halt status and the configuration it clears.
    always_ff @(posedge osc_clk_i) begin
        if (osc_rst) begin
            osc_halt_status <= 1'b1;
        end else if (wr_go && req_q.addr == brac_pkg::REG_CTRL2) begin
            osc_halt_status <= 1'b0;
        end
    end

    always_ff @(posedge osc_clk_i) begin
        if (osc_rst || osc_halt_status) begin
            trim <= 8'h00;
            ctrl1 <= '0;
            clock_out_control <= 1'b0;
        end else if (wr_go) begin
            case (req_q.addr)
                brac_pkg::REG_TRIM: trim <= req_q.wdata;
                brac_pkg::REG_CTRL1: ctrl1 <= brac_pkg::brac_ctrl1_s'(req_q.wdata);
                brac_pkg::REG_CTRL2: clock_out_control <= req_q.wdata[brac_pkg::CTRL2_CLOCK_OUT_CONTROL_BIT];
                default: ;
            endcase
        end
    end

    // Alarms are judged one cycle after the minute moves, when seconds read zero.
    logic min_evt;
    logic [1:0] al_hit;
    logic [1:0] al_en;
    logic [1:0] flag_clr;

    assign al_en = {ctrl1.alarm_two_enable, ctrl1.alarm_one_enable};
    assign flag_clr = (wr_go && req_q.addr == brac_pkg::REG_CTRL2)
                      ? ~req_q.wdata[brac_pkg::CTRL2_AFG1_BIT:brac_pkg::CTRL2_AFG2_BIT] : 2'b00;

    always_ff @(posedge osc_clk_i) begin
        if (osc_rst) begin
            min_evt <= 1'b0;
        end else begin
            min_evt <= min_step;
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_alarm
            assign al_hit[i] = min_evt && al_en[i] && al_days[i][wday[2:0]]
                               && al_min[i] == min && al_hour[i] == hr;
            always_ff @(posedge osc_clk_i) begin
                if (osc_rst) begin
                    afg[1 - i] <= 1'b0;
                end else if (al_hit[i]) begin
                    afg[1 - i] <= 1'b1;
                end else if (flag_clr[1 - i]) begin
                    afg[1 - i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Periodic interrupt, active high internally.
    logic [16:0] half;
    logic [16:0] quarter;
    logic level_evt;
    logic int_act;

    assign half = 17'(period >>> 1);
    assign quarter = 17'(period >>> 2);

    always_comb begin
        case (ctrl1.cycle)
            brac_pkg::CYC_SEC: level_evt = sec_tick || adj_go;
            brac_pkg::CYC_MIN: level_evt = min_step;
            brac_pkg::CYC_HOUR: level_evt = hour_step;
            brac_pkg::CYC_MONTH: level_evt = month_step;
            default: level_evt = 1'b0;
        endcase
    end

    always_ff @(posedge osc_clk_i) begin
        if (osc_rst) begin
            periodic_flag <= 1'b0;
        end else if (level_evt) begin
            periodic_flag <= 1'b1;
        end else if (wr_go && req_q.addr == brac_pkg::REG_CTRL2 && !req_q.wdata[brac_pkg::CTRL2_PERIODIC_FLAG_BIT]) begin
            periodic_flag <= 1'b0;
        end else if (!ctrl1.cycle[2]) begin
            periodic_flag <= 1'b0;
        end
    end

    always_comb begin
        case (ctrl1.cycle)
            brac_pkg::CYC_OFF: int_act = 1'b0;
            brac_pkg::CYC_LOW: int_act = 1'b1;
            brac_pkg::CYC_2HZ: int_act = (sub < quarter) || (sub >= half && sub < half + quarter);
            brac_pkg::CYC_1HZ: int_act = (sub < half);
            default: int_act = periodic_flag;
        endcase
    end

    // Pin routing. The crystal clock is gated straight onto the second pin; this
    // keeps its full rate at the cost of a combinational path from the clock net.
    logic first_low;
    logic second_low;
    logic clk_on;

    assign clk_on = !clock_out_control && !osc_rst;
    assign first_low = afg[1] || (afg[0] && !ctrl1.route_select_low)
                       || (int_act && !ctrl1.route_select_high);
    assign second_low = (clk_on && !osc_clk_i) || (afg[0] && ctrl1.route_select_low)
                        || (int_act && ctrl1.route_select_high);

    assign irq_out_first_o = 1'b0;
    assign irq_out_first_oe_n_o = !first_low;
    assign irq_out_second_o = 1'b0;
    assign irq_out_second_oe_n_o = !second_low;

    // Read capture; the result is stable before the acknowledge toggle crosses back.
    always_ff @(posedge osc_clk_i) begin
        if (osc_rst) begin
            rd_q <= 8'h00;
        end else if (op_go && !req_q.we) begin
            case (req_q.addr)
                brac_pkg::REG_SECONDS: rd_q <= sec;
                brac_pkg::REG_MINUTES: rd_q <= min;
                brac_pkg::REG_HOURS: rd_q <= hr;
                brac_pkg::REG_WEEKDAY: rd_q <= wday;
                brac_pkg::REG_DATE: rd_q <= date;
                brac_pkg::REG_MONTH: rd_q <= mon;
                brac_pkg::REG_YEAR: rd_q <= yr;
                brac_pkg::REG_TRIM: rd_q <= trim;
                brac_pkg::REG_AL1_MIN: rd_q <= al_min[0];
                brac_pkg::REG_AL1_HOUR: rd_q <= al_hour[0];
                brac_pkg::REG_AL1_DAYS: rd_q <= {1'b0, al_days[0]};
                brac_pkg::REG_AL2_MIN: rd_q <= al_min[1];
                brac_pkg::REG_AL2_HOUR: rd_q <= al_hour[1];
                brac_pkg::REG_AL2_DAYS: rd_q <= {1'b0, al_days[1]};
                brac_pkg::REG_CTRL1: rd_q <= ctrl1;
                default: rd_q <= {2'b00, fmt24, osc_halt_status, clock_out_control, int_act, afg};
            endcase
        end
    end

endmodule : brac_core

`default_nettype wire

// >>> rtl/brac_pkg_dummy_guard.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// >>> sim/brac_host_model.sv
`timescale 1ns/100ps
`default_nettype none
package brac_vpkg;
    function automatic logic [7:0] brac_used(input logic [3:0] a);
        case (a)
            4'h0, 4'h1, 4'h8, 4'hA, 4'hB, 4'hD: return 8'h7F;
            4'h2, 4'h4, 4'h9, 4'hC, 4'hF: return 8'h3F;
            4'h3: return 8'h07;
            4'h5: return 8'h1F;
            default: return 8'hFF;
        endcase
    endfunction : brac_used
endpackage : brac_vpkg

module brac_host_model (
    input wire logic clk_i,
    input wire logic req_ready_i,
    input wire logic rsp_valid_i,
    input wire logic [7:0] rsp_data_i,
    output logic req_valid_o,
    output brac_pkg::brac_req_s req_o
);
    logic [7:0] rd_data;
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
        rd_data = 8'h00;
    end
    // The request stays put until ready is sampled high; the payload is inverted once released.
    task automatic xfer(input logic we, input logic [3:0] addr, input logic [7:0] wdata, output logic ok);
        int n;
        n = 0;
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_o <= '{we: we, addr: addr, wdata: wdata};
        @(posedge clk_i);
        while (req_ready_i !== 1'b1) @(posedge clk_i);
        req_valid_o <= 1'b0;
        req_o <= ~req_o;
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp_valid_i !== 1'b1 && n < 100);
        rd_data = rsp_data_i;
        ok = (rsp_valid_i === 1'b1);
    endtask : xfer
endmodule : brac_host_model
`default_nettype wire

// >>> sim/brac_core_sva.sv
`timescale 1ns/100ps
`default_nettype none
module brac_core_sva (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic osc_clk_i,
    input wire logic req_valid_i,
    input wire brac_pkg::brac_req_s req_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    input wire logic [7:0] rsp_data_o,
    input wire logic irq_out_first_o,
    input wire logic irq_out_first_oe_n_o,
    input wire logic irq_out_second_o,
    input wire logic irq_out_second_oe_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic rd_q;
    logic [3:0] addr_q;
    wire logic taken = req_valid_i && req_ready_o;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rd_q <= 1'b0;
            addr_q <= 4'h0;
        end else if (taken) begin
            rd_q <= !req_i.we;
            addr_q <= req_i.addr;
        end
    end
    rsp_one_cycle_a: assert property (rsp_valid_o |=> !rsp_valid_o) else $error("answer held too long");
    ready_drop_a: assert property (taken |=> !req_ready_o) else $error("ready stayed up");
    rsp_bound_a: assert property (taken |-> ##[2:40] rsp_valid_o) else $error("no answer");
    ready_rise_a: assert property ($rose(req_ready_o) |-> rsp_valid_o) else $error("ready without answer");
    rsp_busy_a: assert property (rsp_valid_o |-> !$past(req_ready_o)) else $error("answer while idle");
    data_hold_a: assert property (!rsp_valid_o && !$past(srst_i) |-> $stable(rsp_data_o))
        else $error("read data moved");
    empty_bits_a: assert property (rsp_valid_o && rd_q |-> (rsp_data_o & ~brac_vpkg::brac_used(addr_q)) == 8'h00)
        else $error("empty bit set");
    first_pin_a: assert property (irq_out_first_o == 1'b0) else $error("first pin drives high");
    second_pin_a: assert property (irq_out_second_o == 1'b0) else $error("second pin drives high");
    cover property (taken && req_i.we);
    cover property (rsp_valid_o && rd_q);
    cover property ($fell(irq_out_first_oe_n_o));
endmodule : brac_core_sva
bind brac_core brac_core_sva u_sva (.clk_i(clk_i), .srst_i(srst_i), .osc_clk_i(osc_clk_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .irq_out_first_o(irq_out_first_o), .irq_out_first_oe_n_o(irq_out_first_oe_n_o),
    .irq_out_second_o(irq_out_second_o), .irq_out_second_oe_n_o(irq_out_second_oe_n_o));
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic osc_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic req_valid, req_ready, rsp_valid, ok, d1, d2, oe1_n, oe2_n;
    brac_pkg::brac_req_s req;
    logic [7:0] rsp_data, v;
    logic [3:0] a;
    logic [63:0] r;
    int n_mismatch = 0;
    int samples_checked = 0;
    int lo1, lo2, per;
    // Row: weekday, date, month, year written; then weekday, date, month, year expected.
    logic [63:0] tv [3] = '{64'h06_28_02_04_00_29_02_04, 64'h02_28_02_03_03_01_03_03, 64'h05_31_12_99_06_01_01_00};
    logic [7:0] pc [5] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h01};
    initial forever #20 clk_i = ~clk_i;
    initial begin
        #3;
        forever #7.5 osc_clk_i = ~osc_clk_i;
    end
    // Short divider keeps a second at 225 host cycles.
    brac_core #(.DIV_FAST(600), .DIV_SLOW(592), .TRIM_SPAN(2)) dut (.clk_i(clk_i), .srst_i(srst_i),
        .osc_clk_i(osc_clk_i), .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .irq_out_first_o(d1), .irq_out_first_oe_n_o(oe1_n),
        .irq_out_second_o(d2), .irq_out_second_oe_n_o(oe2_n));
    brac_host_model host (.clk_i(clk_i), .req_ready_i(req_ready), .rsp_valid_i(rsp_valid),
        .rsp_data_i(rsp_data), .req_valid_o(req_valid), .req_o(req));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] near(input int x, input int e, input int tol);
        return {15'h0000, (x >= e - tol) && (x <= e + tol)};
    endfunction : near
    task automatic wr(input logic [3:0] wa, input logic [7:0] wd);
        host.xfer(1'b1, wa, wd, ok);
        check({15'h0000, ok}, 16'h0001);
    endtask : wr
    task automatic rd(input logic [3:0] ra, input logic [7:0] e);
        host.xfer(1'b0, ra, 8'h00, ok);
        check({7'h00, ok, host.rd_data}, {8'h01, e});
    endtask : rd
    task automatic measure(input int n);
        lo1 = 0;
        lo2 = 0;
        repeat (n) begin
            @(negedge clk_i);
            lo1 += int'(oe1_n === 1'b0);
            lo2 += int'(oe2_n === 1'b0);
        end
    endtask : measure
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #800000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        void'($urandom(28));
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(4'hF, 8'h30);
        rd(4'h4, 8'h01);
        wr(4'h7, 8'hFF);
        wr(4'hE, 8'h77);
        rd(4'h7, 8'h00);
        rd(4'hE, 8'h00);
        wr(4'hF, 8'h20);
        rd(4'hF, 8'h20);
        repeat (20) begin
            a = 4'(6 + $urandom_range(8));
            v = 8'($urandom);
            if (a == 4'hE) v[3] = 1'b0;
            wr(a, v);
            rd(a, v & brac_vpkg::brac_used(a));
        end
        wr(4'h7, 8'h00);
        wr(4'hE, 8'h80);
        wr(4'h8, 8'h00);
        wr(4'h9, 8'h00);
        wr(4'hA, 8'h01);
        for (int i = 0; i < 3; i++) begin
            r = tv[i];
            wr(4'h2, 8'h23);
            wr(4'h1, 8'h59);
            wr(4'h3, r[63:56]);
            wr(4'h4, r[55:48]);
            wr(4'h5, r[47:40]);
            wr(4'h6, r[39:32]);
            wr(4'hF, 8'h20);
            wr(4'h0, 8'h59);
            repeat (300) @(posedge clk_i);
            rd(4'h4, r[23:16]);
            rd(4'h5, r[15:8]);
            rd(4'h6, r[7:0]);
            rd(4'h3, r[31:24]);
            rd(4'h2, 8'h00);
            rd(4'h1, 8'h00);
            rd(4'hF, (r[31:24] == 8'h00) ? 8'h22 : 8'h20);
            check({15'h0000, oe1_n}, {15'h0000, r[31:24] != 8'h00});
        end
        wr(4'hF, 8'h20);
        check({15'h0000, oe1_n}, 16'h0001);
        wr(4'h1, 8'h10);
        wr(4'h0, 8'h10);
        wr(4'hF, 8'h30);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h10);
        wr(4'h0, 8'h45);
        wr(4'hF, 8'h30);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h11);
        wr(4'h7, 8'hC0);
        wr(4'hF, 8'h30);
        repeat (190) @(posedge clk_i);
        rd(4'h0, 8'h01);
        wr(4'h7, 8'h00);
        wr(4'hF, 8'h28);
        foreach (pc[i]) begin
            wr(4'hE, pc[i]);
            measure(225);
            per = (pc[i][1:0] == 2'b01) ? 225 : (pc[i][1] ? 112 : 0);
            check(near(lo1, pc[i][5] ? 0 : per, 8), 16'h0001);
            check(near(lo2, pc[i][5] ? per : 0, 8), 16'h0001);
        end
        rd(4'hF, 8'h2C);
        wr(4'hE, 8'h00);
        wr(4'hF, 8'h20);
        measure(100);
        check(near(lo2, 50, 40), 16'h0001);
        check(near(lo1, 0, 0), 16'h0001);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
